// >>> rtl/rdcr_regs.sv
// Channel 1 and 2 configuration register bank with tracking and source select
`timescale 1ns/1ps
module rdcr_regs
  import rdcr_pkg::*;
(
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_ARST_N,
  input  wire logic                 i_WR,
  input  wire logic [ADDR_W-1:0]    i_ADDR,
  input  wire logic [DATA_W-1:0]    i_WDATA,
  input  wire logic [2:0]           i_PIN_EQ_LEVEL,
  input  wire logic [1:0]           i_PIN_RX_GAIN,
  output logic      [DATA_W-1:0]    o_RDATA,
  output logic      [3:0][2:0]      o_EQUALIZER_LEVEL,
  output logic      [3:0]           o_TX_GAIN_6DB,
  output logic      [3:0]           o_EQUALIZER_DC_ATTENUATION,
  output logic      [3:0][1:0]      o_RX_GAIN,
  output logic      [3:0]           o_OUTPUT_AC_PEAKING,
  output logic      [3:0]           o_EQUALIZER_STAGE_DISABLE,
  output logic      [3:0]           o_OUTPUT_STAGE_DISABLE,
  output logic                      o_PIN_CONTROL_SELECT
);
  import rdcr_pkg::*;

  typedef struct packed {
    logic [7:0]      general;
    logic [2:0]      pin_eq_meta;
    logic [2:0]      pin_eq_sync;
    logic [1:0]      pin_rx_meta;
    logic [1:0]      pin_rx_sync;
    logic [7:0]      rdata;
    logic [3:0][7:0] ctrl_out;
    logic [3:0][7:0] enab_out;
    logic            pin_sel;
    logic [3:0]      dc_att;
  } rdcr_top_s;

  rdcr_top_s  state_reg;
  rdcr_top_s  state_next;
  logic [7:0] ch1_control;
  logic [7:0] ch1_enables;
  logic [7:0] ch2_control;
  logic [7:0] ch2_enables;

  rdcr_channel #(.CTRL_ADDR(CHAN1_CONTROL_ADDR), .ENAB_ADDR(CHAN1_STAGE_ENABLES_ADDR)) u_ch1 (
    .i_clock   (I_CLOCK),
    .i_arst_n  (I_ARST_N),
    .i_wr      (i_WR),
    .i_addr    (i_ADDR),
    .i_wdata   (i_WDATA),
    .o_control (ch1_control),
    .o_enables (ch1_enables)
  );

  rdcr_channel #(.CTRL_ADDR(CHAN2_CONTROL_ADDR), .ENAB_ADDR(CHAN2_STAGE_ENABLES_ADDR)) u_ch2 (
    .i_clock   (I_CLOCK),
    .i_arst_n  (I_ARST_N),
    .i_wr      (i_WR),
    .i_addr    (i_ADDR),
    .i_wdata   (i_WDATA),
    .o_control (ch2_control),
    .o_enables (ch2_enables)
  );

  always_comb begin
    logic [7:0] src_ctrl1;
    logic [7:0] src_ctrl2;
    src_ctrl1  = ch1_control;
    src_ctrl2  = ch2_control;
    state_next = state_reg;
    // Pin strap inputs come from off chip and are double-registered
    state_next.pin_eq_meta = i_PIN_EQ_LEVEL;
    state_next.pin_eq_sync = state_reg.pin_eq_meta;
    state_next.pin_rx_meta = i_PIN_RX_GAIN;
    state_next.pin_rx_sync = state_reg.pin_rx_meta;
    if (i_WR && i_ADDR == GENERAL_SETTINGS_ADDR) begin
      state_next.general = i_WDATA & GENERAL_MASK;
    end
    // Pin control replaces the equalizer level and receiver gain fields
    state_next.pin_sel = state_reg.general[PIN_SELECT_BIT];
    if (state_reg.general[PIN_SELECT_BIT]) begin
      src_ctrl1[EQ_LEVEL_MSB:EQ_LEVEL_LSB] = state_reg.pin_eq_sync;
      src_ctrl1[RX_GAIN_MSB:RX_GAIN_LSB]   = state_reg.pin_rx_sync;
      src_ctrl2[EQ_LEVEL_MSB:EQ_LEVEL_LSB] = state_reg.pin_eq_sync;
      src_ctrl2[RX_GAIN_MSB:RX_GAIN_LSB]   = state_reg.pin_rx_sync;
    end
    // Channels 0 and 3 have no registers here; channel 0 follows channel 1, channel 3 follows channel 2 unless TRACK_ALL_BIT is clear, then channel 1
    state_next.ctrl_out[1] = src_ctrl1;
    state_next.enab_out[1] = ch1_enables;
    state_next.ctrl_out[2] = src_ctrl2;
    state_next.enab_out[2] = ch2_enables;
    state_next.ctrl_out[0] = src_ctrl1;
    state_next.enab_out[0] = ch1_enables;
    state_next.ctrl_out[3] = src_ctrl2;
    state_next.enab_out[3] = ch2_enables;
    if (!state_reg.general[TRACK_ALL_BIT]) begin
      state_next.ctrl_out[2] = src_ctrl1;
      state_next.enab_out[2] = ch1_enables;
      state_next.ctrl_out[3] = src_ctrl1;
      state_next.enab_out[3] = ch1_enables;
    end
    // Attenuation flag is the inverse of the gain bit, kept in a flop so the pin is glitch free
    for (int c = 0; c < 4; c++) begin
      state_next.dc_att[c] = ~state_next.ctrl_out[c][EQ_DC_ATTEN_BIT];
    end
    case (i_ADDR)
      GENERAL_SETTINGS_ADDR:    state_next.rdata = state_reg.general;
      CHAN1_CONTROL_ADDR:       state_next.rdata = ch1_control;
      CHAN1_STAGE_ENABLES_ADDR: state_next.rdata = ch1_enables;
      CHAN2_CONTROL_ADDR:       state_next.rdata = ch2_control;
      CHAN2_STAGE_ENABLES_ADDR: state_next.rdata = ch2_enables;
      default:                  state_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg        <= '0;
      state_reg.dc_att <= 4'hf;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_RDATA              = state_reg.rdata;
  assign o_PIN_CONTROL_SELECT = state_reg.pin_sel;

  for (genvar c = 0; c < 4; c++) begin : g_fields
    assign o_EQUALIZER_LEVEL[c]          = state_reg.ctrl_out[c][EQ_LEVEL_MSB:EQ_LEVEL_LSB];
    assign o_TX_GAIN_6DB[c]              = state_reg.ctrl_out[c][TX_GAIN_BIT];
    assign o_EQUALIZER_DC_ATTENUATION[c] = state_reg.dc_att[c];
    assign o_RX_GAIN[c]         = state_reg.ctrl_out[c][RX_GAIN_MSB:RX_GAIN_LSB];
    assign o_OUTPUT_AC_PEAKING[c]        = state_reg.enab_out[c][PEAKING_BIT];
    assign o_EQUALIZER_STAGE_DISABLE[c]  = state_reg.enab_out[c][EQ_DISABLE_BIT];
    assign o_OUTPUT_STAGE_DISABLE[c]     = state_reg.enab_out[c][OUT_DISABLE_BIT];
  end

  a_ch1_write_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_WR && i_ADDR == CHAN1_CONTROL_ADDR) ##1 (!i_WR && i_ADDR == CHAN1_CONTROL_ADDR)
    |=> o_RDATA == $past(i_WDATA, 2)) else $error("channel 1 control readback wrong");
  a_ch2_enab_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_WR && i_ADDR == CHAN2_STAGE_ENABLES_ADDR) ##1 (!i_WR && i_ADDR == CHAN2_STAGE_ENABLES_ADDR)
    |=> o_RDATA == ($past(i_WDATA, 2) & 8'h07)) else $error("channel 2 enable readback wrong");
  a_reset_zero: assert property (@(posedge I_CLOCK)
    $rose(I_ARST_N) |-> (ch1_control == 8'h00 && ch2_enables == 8'h00)) else $error("not zero after reset");
  a_eq_level_map: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !state_reg.general[PIN_SELECT_BIT] ##1 !state_reg.general[PIN_SELECT_BIT]
    |=> o_EQUALIZER_LEVEL[1] == $past(ch1_control[6:4])) else $error("eq level mismatch");
  a_tx_gain_map: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg.general[TRACK_ALL_BIT]
    |=> o_TX_GAIN_6DB[2] == $past(ch2_control[TX_GAIN_BIT])) else $error("tx gain mismatch");
  a_dc_atten_inv: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    1'b1 |=> o_EQUALIZER_DC_ATTENUATION[1] == !$past(ch1_control[EQ_DC_ATTEN_BIT]))
    else $error("dc gain polarity");
  a_track_all: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (!state_reg.general[TRACK_ALL_BIT] && !i_WR)[*2] |-> o_RX_GAIN[3] == o_RX_GAIN[1])
    else $error("tracking failed");
  a_peak_disable: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    1'b1 |=> {o_OUTPUT_AC_PEAKING[1], o_EQUALIZER_STAGE_DISABLE[1], o_OUTPUT_STAGE_DISABLE[1]}
      == $past(ch1_enables[2:0])) else $error("enable fields mismatch");

  // Read path: unmapped places and the read-only enable bits must never leak data
  a_unmapped_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_ADDR == 8'h03) |=> o_RDATA == 8'h00) else $error("unmapped read not zero");
  a_enab_read_upper: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_ADDR == CHAN1_STAGE_ENABLES_ADDR)
    |=> o_RDATA[7:3] == 5'h00) else $error("enable upper bits read nonzero");
  a_ch2_ctrl_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_ADDR == CHAN2_CONTROL_ADDR)
    |=> o_RDATA == $past(ch2_control)) else $error("channel 2 control read wrong");

  // Write path into the channel pairs
  a_ctrl_bit7_store: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_WR && i_ADDR == CHAN1_CONTROL_ADDR)
    |=> ch1_control[7] == $past(i_WDATA[7])) else $error("reserved bit not stored");
  a_enab_write_mask: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    (i_WR && i_ADDR == CHAN2_STAGE_ENABLES_ADDR)
    |=> ch2_enables == ($past(i_WDATA) & 8'h07)) else $error("enable write mask wrong");

  // Source selection between pin straps and registers
  a_pin_sel_copy: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    1'b1 |=> o_PIN_CONTROL_SELECT == $past(state_reg.general[PIN_SELECT_BIT]))
    else $error("pin select output wrong");
  a_pin_eq_path: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg.general[PIN_SELECT_BIT]
    |=> o_EQUALIZER_LEVEL[1] == $past(state_reg.pin_eq_sync)) else $error("pin eq not used");
  a_pin_rx_path: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg.general[PIN_SELECT_BIT]
    |=> o_RX_GAIN[1] == $past(state_reg.pin_rx_sync)) else $error("pin rx gain not used");
  a_reg_rx_map: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    !state_reg.general[PIN_SELECT_BIT]
    |=> o_RX_GAIN[1] == $past(ch1_control[1:0])) else $error("rx gain mismatch");

  // Tracking of the channels that have no registers of their own
  a_track_ch0: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    1'b1 |=> o_EQUALIZER_STAGE_DISABLE[0] == $past(ch1_enables[EQ_DISABLE_BIT]))
    else $error("channel 0 not tracking");
  a_pair_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_reg.general[TRACK_ALL_BIT]
    |=> o_OUTPUT_STAGE_DISABLE[3] == $past(ch2_enables[OUT_DISABLE_BIT]))
    else $error("channel 3 not tracking");
endmodule

// >>> rtl/rdcr_pkg.sv
// Register map, field layout and reset values of the channel configuration bank
package rdcr_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_CH   = 2;

  localparam logic [7:0] CHAN1_CONTROL_ADDR       = 8'h05;
  localparam logic [7:0] CHAN1_STAGE_ENABLES_ADDR = 8'h06;
  localparam logic [7:0] CHAN2_CONTROL_ADDR       = 8'h08;
  localparam logic [7:0] CHAN2_STAGE_ENABLES_ADDR = 8'h09;
  localparam logic [7:0] GENERAL_SETTINGS_ADDR    = 8'h00;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] GENERAL_RESET = 8'h00;
  localparam logic [7:0] ENABLES_MASK  = 8'h07;
  localparam logic [7:0] GENERAL_MASK  = 8'hff;

  localparam int unsigned EQ_LEVEL_MSB     = 6;
  localparam int unsigned EQ_LEVEL_LSB     = 4;
  localparam int unsigned TX_GAIN_BIT      = 3;
  localparam int unsigned EQ_DC_ATTEN_BIT  = 2;
  localparam int unsigned RX_GAIN_MSB      = 1;
  localparam int unsigned RX_GAIN_LSB      = 0;
  localparam int unsigned PEAKING_BIT      = 2;
  localparam int unsigned EQ_DISABLE_BIT   = 1;
  localparam int unsigned OUT_DISABLE_BIT  = 0;

  localparam int unsigned PIN_SELECT_BIT   = 7;
  localparam int unsigned TRACK_PAIR01_BIT = 5;
  localparam int unsigned TRACK_PAIR23_BIT = 4;
  localparam int unsigned TRACK_ALL_BIT    = 3;

  typedef enum logic [1:0] {
    RDCR_RX_LOW  = 2'h0,
    RDCR_RX_MID  = 2'h1,
    RDCR_RX_HIGH = 2'h3
  } rdcr_rx_gain_e;
endpackage

// >>> rtl/rdcr_channel.sv
// One channel's control and stage enable register pair
`timescale 1ns/1ps
module rdcr_channel
  import rdcr_pkg::*;
#(
  parameter logic [7:0] CTRL_ADDR = 8'h05,
  parameter logic [7:0] ENAB_ADDR = 8'h06
) (
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_control,
  output logic      [7:0]  o_enables
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] enables;
  } rdcr_chan_s;

  rdcr_chan_s state_reg;
  rdcr_chan_s state_next;

  always_comb begin
    state_next = state_reg;
    if (i_wr && i_addr == CTRL_ADDR) begin
      state_next.control = i_wdata;
    end
    if (i_wr && i_addr == ENAB_ADDR) begin
      state_next.enables = i_wdata & ENABLES_MASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '{control: CONTROL_RESET, enables: ENABLES_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_control = state_reg.control;
  assign o_enables = state_reg.enables;

  a_enab_upper_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    state_reg.enables[7:3] == 5'h00) else $error("enable upper bits not zero");
endmodule

// >>> verif/rdcr_host_model.sv
// Parallel bus host model that writes and reads the channel configuration registers
`timescale 1ns/1ps
module rdcr_host_model
  import rdcr_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic [DATA_W-1:0] i_rdata,
  output logic                   o_wr,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_addr  = 8'hff;
    o_wdata = 8'h00;
  end
  // Data is inverted after the strobe so a stale bus value is never mistaken for a write
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_wr    = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clock);
    #1;
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_addr = a;
    @(posedge i_clock);
    #1;
    d = i_rdata;
  endtask
endmodule

// >>> verif/tb_redriver_channel_config_regs.sv
// Self-checking bench for the channel configuration register bank
`timescale 1ns/1ps
module tb_redriver_channel_config_regs;
  import rdcr_pkg::*;
  logic            clk;
  logic            arst_n;
  logic            wr;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic [7:0]      got;
  logic [7:0]      d;
  logic [2:0]      pin_eq;
  logic [1:0]      pin_rx;
  logic [3:0][2:0] eq_lvl;
  logic [3:0][1:0] rx_gain;
  logic [3:0]      tx_gain;
  logic [3:0]      dc_att;
  logic [3:0]      peak;
  logic [3:0]      eq_dis;
  logic [3:0]      out_dis;
  logic            pin_sel;
  logic [7:0]      shadow [16];
  logic [7:0]      addr_tab [5] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h03};
  logic [1:0]      rx_tab [3] = '{2'h0, 2'h1, 2'h3};
  logic [31:0]     lfsr = 32'h00012088;
  int              mismatches = 0;
  int              checks_done = 0;

  rdcr_host_model rdcr_host_model_inst (.i_clock(clk), .i_rdata(rdata), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata));
  rdcr_regs rdcr_regs_inst (.I_CLOCK(clk), .I_ARST_N(arst_n), .i_WR(wr), .i_ADDR(addr),
    .i_WDATA(wdata), .i_PIN_EQ_LEVEL(pin_eq), .i_PIN_RX_GAIN(pin_rx), .o_RDATA(rdata),
    .o_EQUALIZER_LEVEL(eq_lvl), .o_TX_GAIN_6DB(tx_gain), .o_EQUALIZER_DC_ATTENUATION(dc_att),
    .o_RX_GAIN(rx_gain), .o_OUTPUT_AC_PEAKING(peak), .o_EQUALIZER_STAGE_DISABLE(eq_dis),
    .o_OUTPUT_STAGE_DISABLE(out_dis), .o_PIN_CONTROL_SELECT(pin_sel));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  function automatic logic [7:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0] ^ lfsr[15:8];
  endfunction
  // Only the low three enable bits are storage; unmapped places read as zero
  function automatic logic [7:0] expect_rd(input logic [7:0] a);
    case (a)
      CHAN1_CONTROL_ADDR, CHAN2_CONTROL_ADDR, GENERAL_SETTINGS_ADDR: return shadow[a[3:0]];
      CHAN1_STAGE_ENABLES_ADDR, CHAN2_STAGE_ENABLES_ADDR: return shadow[a[3:0]] & 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic check_chan(input int c, input logic [7:0] ct, input logic [7:0] en);
    check({5'h00, eq_lvl[c]}, {5'h00, ct[6:4]});
    check({7'h00, tx_gain[c]}, {7'h00, ct[3]});
    check({7'h00, dc_att[c]}, {7'h00, ~ct[2]});
    check({6'h00, rx_gain[c]}, {6'h00, ct[1:0]});
    check({5'h00, peak[c], eq_dis[c], out_dis[c]}, {5'h00, en[2:0]});
  endtask
  task automatic conclude();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
    shadow[a[3:0]] = v;
    rdcr_host_model_inst.write(a, v);
    rdcr_host_model_inst.read(a, got);
    check(got, expect_rd(a));
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    pin_eq = 3'h0;
    pin_rx = 2'h0;
    for (int i = 0; i < 16; i++) shadow[i] = 8'h00;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdcr_host_model_inst.read(addr_tab[i], got);
      check(got, 8'h00);
    end
    check_chan(1, 8'h00, 8'h00);
    $display("test reset values done");
    wr_rd(GENERAL_SETTINGS_ADDR, 8'h08);
    for (int i = 0; i < 25; i++) begin
      d = (i < 5) ? 8'hff : next_rand();
      wr_rd(addr_tab[i % 5], d);
    end
    for (int k = 0; k < 3; k++) wr_rd(CHAN2_CONTROL_ADDR, {1'b1, 3'(k * 3), 2'h0, rx_tab[k]});
    check_chan(1, shadow[5], shadow[6]);
    check_chan(2, shadow[8], shadow[9]);
    check_chan(0, shadow[5], shadow[6]);
    check_chan(3, shadow[8], shadow[9]);
    $display("test access and fields done");
    wr_rd(GENERAL_SETTINGS_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    check_chan(2, shadow[5], shadow[6]);
    check_chan(3, shadow[5], shadow[6]);
    $display("test track all done");
    check({7'h00, pin_sel}, 8'h00);
    wr_rd(GENERAL_SETTINGS_ADDR, 8'h80);
    @(posedge clk);
    #1;
    d = next_rand();
    pin_eq = d[2:0];
    pin_rx = 2'h3;
    repeat (6) @(posedge clk);
    check({7'h00, pin_sel}, 8'h01);
    check({5'h00, eq_lvl[1]}, {5'h00, pin_eq});
    check({6'h00, rx_gain[1]}, {6'h00, pin_rx});
    check({7'h00, tx_gain[1]}, {7'h00, shadow[5][3]});
    $display("test pin select done");
    conclude();
  end
endmodule
